/* File: rtl/sevr_regs.vh */
`ifndef SEVR_REGS_VH
`define SEVR_REGS_VH
`define SEVR_CMD_READ_STD 4'h0
`define SEVR_CMD_READ_A 4'h1
`define SEVR_CMD_READ_B 4'h2
`define SEVR_CMD_CLEAR 4'h3
`define SEVR_CMD_MASK_STD 4'h4
`define SEVR_CMD_MASK_A 4'h5
`define SEVR_CMD_MASK_B 4'h6
`define SEVR_CMD_IDENT 4'h7
`define SEVR_CMD_IST 4'h8
`define SEVR_CMD_CONFIG 4'h9
`define SEVR_CMD_OPC 4'ha
`define SEVR_CMD_OPC_Q 4'hb
`define SEVR_CMD_PSC_WR 4'hc
`define SEVR_CMD_PSC_Q 4'hd
`define SEVR_CMD_RECALL 4'he
`define SEVR_BIT_OPC 0
`define SEVR_BIT_EXE 4
`define SEVR_BIT_CME 5
`define SEVR_BIT_SEQUENCE_ERROR_BIT 5
`define SEVR_SUM_STD 5
`define SEVR_SUM_A 2
`define SEVR_SUM_B 3
`define SEVR_BIT_MAV 4
`define SEVR_IDENT_LEN 8'd49
`define SEVR_CONFIG_LEN 8'd202
`define SEVR_ASCII_0 8'h30
`define SEVR_ASCII_1 8'h31
`define SEVR_SETUP_LAST 8'h0a
`define SEVR_ERR_EMPTY 8'h18
`define SEVR_ERR_LIMIT 8'h15
`define SEVR_MASK_RESET 8'h00
`define SEVR_ERR_SHOW_MS 500
`define SEVR_CLOCK_KHZ 250000
`endif

/* File: rtl/sevr_status_event_recall.v */
// Summary of operation
// - A rising monitored condition sets its event latch bit on positive-edge inputs.
// - A falling monitored condition sets its event latch bit on negative-edge inputs.
// - A set latch bit stays set until its own latch is read or the clear-status command is taken.
// - Three separate eight-bit event latches, each with its own query command.
// - Reading a latch returns its content and then clears it.
// - The clear-status command clears all three latches together.
// - A latch query answers with the latch value, 0 to 255.
// - Each latch has its own mask register in matching position.
// - The identification reply is a fixed 49 character string.
// - Status query returns ASCII 0 or 1 and leaves status unchanged.
// - With only the serial interface fitted, status query always answers 1.
// - The configuration reply is a fixed 202 character resendable string.
// - Operation-complete command sets its latch bit after earlier commands finish.
// - Operation-complete query replies 1 and raises message-available after completion.
// - Power-on clear flag 1 clears the masks at shutdown, 0 keeps them.
// - The power-on clear flag survives power-off and clear commands.
// - Slots 1 to 10 restore the full setup; power-on, trigger, display kept.
// - Slots 11 to 255 restore only voltage, current and dwell time.
// - Empty sequence slot is not executed; shows error 24 and sets bit 5.
// - Setpoint over soft limit aborts recall; shows error 21 and sets bit 5.
// - Sequence slots are recallable even with the sequence function uninitialised.
// - In recall trigger mode an external trigger event performs a recall.
// - A group summary is true while any enabled latch bit is true.
// - The three group summaries sit at status bits 2, 3 and 5.
`timescale 1ns/1ps
`include "sevr_regs.vh"
module sevr_status_event_recall #(
  parameter [7:0] STD_RISE = 8'hff,
  parameter [7:0] A_RISE = 8'hff,
  parameter [7:0] B_RISE = 8'hff,
  parameter VW = 16,
  parameter ERR_SHOW_CYCLES = `SEVR_ERR_SHOW_MS * `SEVR_CLOCK_KHZ
) (
  input wire clock,
  input wire rst_n,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [3:0] cmd_code,
  input wire [7:0] cmd_arg,
  input wire exec_busy,
  output reg resp_valid,
  input wire resp_ready,
  output reg [3:0] resp_kind,
  output reg [7:0] resp_data,
  output reg [7:0] resp_len,
  input wire [7:0] std_cond,
  input wire [7:0] cond_a,
  input wire [7:0] cond_b,
  output reg [7:0] standard_event_latch,
  output reg [7:0] event_latch_a,
  output reg [7:0] event_latch_b,
  output reg [7:0] standard_event_mask,
  output reg [7:0] event_mask_a,
  output reg [7:0] event_mask_b,
  output wire [7:0] status_summary,
  output wire message_available_bit,
  input wire local_status_message,
  input wire serial_only,
  output reg power_on_clear_flag,
  input wire shutdown,
  input wire trigger_mode_recall,
  input wire ext_trigger,
  input wire [7:0] recall_mode_value,
  output reg setup_recall,
  output reg [7:0] setup_slot,
  output reg [7:0] seq_addr,
  input wire seq_empty,
  input wire [VW-1:0] seq_voltage,
  input wire [VW-1:0] seq_current,
  input wire [VW-1:0] seq_dwell,
  input wire [VW-1:0] voltage_soft_limit,
  input wire [VW-1:0] current_soft_limit,
  output reg [VW-1:0] voltage_setpoint,
  output reg [VW-1:0] current_setpoint,
  output reg [VW-1:0] step_dwell_time,
  output reg [7:0] error_display,
  output wire error_shown
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_OPC = 3'd1;
  localparam [2:0] ST_OPC_Q = 3'd2;
  localparam [2:0] ST_FETCH = 3'd3;
  localparam [2:0] ST_CHECK = 3'd4;
  localparam [31:0] ERR_LAST = ERR_SHOW_CYCLES - 1;
  // Set wins over clear so an edge in the read cycle is kept for the next read.
  function [7:0] latch_next;
    input [7:0] cur;
    input clr;
    input [7:0] edges;
    begin
      latch_next = (clr ? 8'h00 : cur) | edges;
    end
  endfunction
  function [7:0] edge_hits;
    input [7:0] now;
    input [7:0] was;
    input [7:0] rise;
    begin
      edge_hits = (rise & now & ~was) | (~rise & ~now & was);
    end
  endfunction
  reg [2:0] state;
  reg [7:0] std_prev;
  reg [7:0] a_prev;
  reg [7:0] b_prev;
  reg trig_prev;
  reg [31:0] err_count;
  reg opc_set;
  reg exe_set;
  reg cme_set;
  reg sequence_error_bit_set;
  reg rd_std;
  reg rd_a;
  reg rd_b;
  reg clr_all;
  reg reply;
  reg [7:0] reply_data;
  reg [7:0] reply_len;
  reg show_err;
  reg [7:0] show_code;
  wire take = cmd_valid && cmd_ready;
  wire trig_event = trigger_mode_recall && ext_trigger && !trig_prev;
  wire [7:0] std_edges = edge_hits(std_cond, std_prev, STD_RISE);
  wire [7:0] a_edges = edge_hits(cond_a, a_prev, A_RISE);
  wire [7:0] b_edges = edge_hits(cond_b, b_prev, B_RISE);
  // A new command waits until the previous reply is taken, so no reply is lost.
  assign cmd_ready = (state == ST_IDLE) && !resp_valid && !trig_event;
  assign message_available_bit = resp_valid;
  assign error_shown = (err_count != 32'd0);
  assign status_summary = {2'b00,
    |(standard_event_latch & standard_event_mask),
    resp_valid,
    |(event_latch_b & event_mask_b),
    |(event_latch_a & event_mask_a),
    2'b00};
  always @* begin
    opc_set = 1'b0;
    exe_set = 1'b0;
    cme_set = 1'b0;
    sequence_error_bit_set = 1'b0;
    rd_std = 1'b0;
    rd_a = 1'b0;
    rd_b = 1'b0;
    clr_all = 1'b0;
    reply = 1'b0;
    reply_data = 8'h00;
    reply_len = 8'd1;
    show_err = 1'b0;
    show_code = 8'h00;
    case (state)
      ST_IDLE: begin
        if (take) begin
          case (cmd_code)
            `SEVR_CMD_READ_STD: begin
              rd_std = 1'b1;
              reply = 1'b1;
              reply_data = standard_event_latch;
            end
            `SEVR_CMD_READ_A: begin
              rd_a = 1'b1;
              reply = 1'b1;
              reply_data = event_latch_a;
            end
            `SEVR_CMD_READ_B: begin
              rd_b = 1'b1;
              reply = 1'b1;
              reply_data = event_latch_b;
            end
            `SEVR_CMD_CLEAR: clr_all = 1'b1;
            `SEVR_CMD_IDENT: begin
              reply = 1'b1;
              reply_len = `SEVR_IDENT_LEN;
            end
            `SEVR_CMD_CONFIG: begin
              reply = 1'b1;
              reply_len = `SEVR_CONFIG_LEN;
            end
            `SEVR_CMD_IST: begin
              reply = 1'b1;
              reply_data = (serial_only || local_status_message) ?
                `SEVR_ASCII_1 : `SEVR_ASCII_0;
            end
            `SEVR_CMD_PSC_Q: begin
              reply = 1'b1;
              reply_data = power_on_clear_flag ? `SEVR_ASCII_1 : `SEVR_ASCII_0;
            end
            `SEVR_CMD_RECALL: begin
              if (cmd_arg == 8'h00) begin
                exe_set = 1'b1;
              end
            end
            `SEVR_CMD_MASK_STD, `SEVR_CMD_MASK_A, `SEVR_CMD_MASK_B,
            `SEVR_CMD_OPC, `SEVR_CMD_OPC_Q, `SEVR_CMD_PSC_WR: reply = 1'b0;
            default: begin
              cme_set = 1'b1;
            end
          endcase
        end
      end
      ST_OPC: opc_set = !exec_busy;
      ST_OPC_Q: begin
        if (!exec_busy) begin
          reply = 1'b1;
          reply_data = `SEVR_ASCII_1;
        end
      end
      ST_CHECK: begin
        if (seq_empty) begin
          sequence_error_bit_set = 1'b1;
          show_err = 1'b1;
          show_code = `SEVR_ERR_EMPTY;
        end else if (seq_voltage > voltage_soft_limit ||
                     seq_current > current_soft_limit) begin
          sequence_error_bit_set = 1'b1;
          show_err = 1'b1;
          show_code = `SEVR_ERR_LIMIT;
        end
      end
      default: reply = 1'b0;
    endcase
  end
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      std_prev <= 8'h00;
      a_prev <= 8'h00;
      b_prev <= 8'h00;
      trig_prev <= 1'b0;
      standard_event_latch <= 8'h00;
      event_latch_a <= 8'h00;
      event_latch_b <= 8'h00;
      standard_event_mask <= `SEVR_MASK_RESET;
      event_mask_a <= `SEVR_MASK_RESET;
      event_mask_b <= `SEVR_MASK_RESET;
      power_on_clear_flag <= 1'b0;
      resp_valid <= 1'b0;
      resp_kind <= 4'h0;
      resp_data <= 8'h00;
      resp_len <= 8'h00;
      setup_recall <= 1'b0;
      setup_slot <= 8'h00;
      seq_addr <= 8'h00;
      voltage_setpoint <= {VW{1'b0}};
      current_setpoint <= {VW{1'b0}};
      step_dwell_time <= {VW{1'b0}};
      error_display <= 8'h00;
      err_count <= 32'd0;
    end else begin
      std_prev <= std_cond;
      a_prev <= cond_a;
      b_prev <= cond_b;
      trig_prev <= ext_trigger;
      setup_recall <= 1'b0;
      // Latches hold until read or cleared; edges always add in.
      standard_event_latch <= latch_next(standard_event_latch, rd_std | clr_all,
        std_edges | {2'b00, cme_set, exe_set, 3'b000, opc_set});
      event_latch_a <= latch_next(event_latch_a, rd_a | clr_all, a_edges);
      event_latch_b <= latch_next(event_latch_b, rd_b | clr_all,
        b_edges | {2'b00, sequence_error_bit_set, 5'b00000});
      if (resp_valid && resp_ready) begin
        resp_valid <= 1'b0;
      end
      if (reply) begin
        resp_valid <= 1'b1;
        resp_kind <= (state == ST_OPC_Q) ? `SEVR_CMD_OPC_Q : cmd_code;
        resp_data <= reply_data;
        resp_len <= reply_len;
      end
      // Masks survive the clear command; only shutdown with the flag set clears them.
      if (shutdown && power_on_clear_flag) begin
        standard_event_mask <= 8'h00;
        event_mask_a <= 8'h00;
        event_mask_b <= 8'h00;
      end else if (take && cmd_code == `SEVR_CMD_MASK_STD) begin
        standard_event_mask <= cmd_arg;
      end else if (take && cmd_code == `SEVR_CMD_MASK_A) begin
        event_mask_a <= cmd_arg;
      end else if (take && cmd_code == `SEVR_CMD_MASK_B) begin
        event_mask_b <= cmd_arg;
      end
      if (take && cmd_code == `SEVR_CMD_PSC_WR) begin
        power_on_clear_flag <= cmd_arg[0];
      end
      if (show_err) begin
        error_display <= show_code;
        err_count <= ERR_LAST;
      end else if (err_count != 32'd0) begin
        err_count <= err_count - 32'd1;
      end else begin
        error_display <= 8'h00;
      end
      case (state)
        ST_IDLE: begin
          if (take && cmd_code == `SEVR_CMD_OPC) begin
            state <= ST_OPC;
          end else if (take && cmd_code == `SEVR_CMD_OPC_Q) begin
            state <= ST_OPC_Q;
          end else if (take && cmd_code == `SEVR_CMD_RECALL && cmd_arg != 8'h00) begin
            seq_addr <= cmd_arg;
            state <= ST_FETCH;
          end else if (trig_event && recall_mode_value != 8'h00) begin
            seq_addr <= recall_mode_value;
            state <= ST_FETCH;
          end
        end
        ST_OPC, ST_OPC_Q: begin
          if (!exec_busy) begin
            state <= ST_IDLE;
          end
        end
        ST_FETCH: begin
          if (seq_addr <= `SEVR_SETUP_LAST) begin
            setup_recall <= 1'b1;
            setup_slot <= seq_addr;
            state <= ST_IDLE;
          end else begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (!sequence_error_bit_set) begin
            voltage_setpoint <= seq_voltage;
            current_setpoint <= seq_current;
            step_dwell_time <= seq_dwell;
          end
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // sevr_status_event_recall

/* File: testbench/sevr_checker.sv */
`timescale 1ns/1ps
`include "sevr_regs.vh"
module sevr_checker (
  input wire clock,
  input wire rst_n,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [3:0] cmd_code,
  input wire resp_valid,
  input wire resp_ready,
  input wire [7:0] resp_data,
  input wire [7:0] resp_len,
  input wire [7:0] cond_a,
  input wire [7:0] standard_event_latch,
  input wire [7:0] event_latch_a,
  input wire [7:0] event_mask_a,
  input wire [7:0] status_summary,
  input wire message_available_bit,
  input wire serial_only,
  input wire power_on_clear_flag,
  input wire shutdown
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire take = cmd_valid && cmd_ready;
  summary_group_a: assert property (
    status_summary[`SEVR_SUM_A] == |(event_latch_a & event_mask_a)) else $error("summary A wrong");
  summary_fixed_a: assert property (
    status_summary[7:6] == 2'b00 && status_summary[1:0] == 2'b00
    && status_summary[4] == message_available_bit) else $error("status bits wrong");
  reply_hold_a: assert property (
    resp_valid && !resp_ready |=> resp_valid && $stable(resp_data)) else $error("reply dropped");
  edge_rise_a: assert property (
    $rose(cond_a[0]) |-> ##[1:2] event_latch_a[0]) else $error("rising edge missed");
  sticky_error_a: assert property (
    standard_event_latch[5] && !(take && (cmd_code == `SEVR_CMD_READ_STD
    || cmd_code == `SEVR_CMD_CLEAR)) |=> standard_event_latch[5]) else $error("error bit lost");
  read_value_a: assert property (
    take && cmd_code == `SEVR_CMD_READ_A |=> resp_valid && resp_len == 8'h01
    && resp_data == $past(event_latch_a)) else $error("latch reply wrong");
  ident_len_a: assert property (
    take && cmd_code == `SEVR_CMD_IDENT |=> resp_len == 8'd49) else $error("ident length wrong");
  serial_ist_a: assert property (
    take && cmd_code == `SEVR_CMD_IST && serial_only |=> resp_data == 8'h31)
    else $error("serial status wrong");
  shutdown_clear_a: assert property (
    shutdown && power_on_clear_flag |=> event_mask_a == 8'h00) else $error("mask kept");
endmodule // sevr_checker
bind sevr_status_event_recall sevr_checker i_sevr_checker (.clock(clock), .rst_n(rst_n),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code), .resp_valid(resp_valid),
  .resp_ready(resp_ready), .resp_data(resp_data), .resp_len(resp_len), .cond_a(cond_a),
  .standard_event_latch(standard_event_latch), .event_latch_a(event_latch_a),
  .event_mask_a(event_mask_a), .status_summary(status_summary),
  .message_available_bit(message_available_bit), .serial_only(serial_only),
  .power_on_clear_flag(power_on_clear_flag), .shutdown(shutdown));

/* File: testbench/sevr_ctl_model.sv */
`timescale 1ns/1ps
module sevr_ctl_model (
  input wire clock,
  input wire cmd_ready,
  input wire resp_valid,
  input wire [7:0] resp_data,
  input wire [7:0] resp_len,
  output reg cmd_valid,
  output reg [3:0] cmd_code,
  output reg [7:0] cmd_arg,
  output reg resp_ready
);
  integer lag;
  reg [7:0] got_data;
  reg [7:0] got_len;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 4'h0;
    cmd_arg = 8'h00;
    resp_ready = 1'b0;
    lag = 0;
  end
  // Released lines are inverted so a stale code can never look valid.
  task send(input [3:0] c, input [7:0] a);
    begin
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_arg <= a;
      @(posedge clock);
      while (cmd_ready !== 1'b1) @(posedge clock);
      cmd_valid <= 1'b0;
      cmd_code <= ~c;
      cmd_arg <= ~a;
    end
  endtask
  task query(input [3:0] c, input [7:0] a);
    begin
      send(c, a);
      repeat (lag) @(posedge clock);
      resp_ready <= 1'b1;
      @(posedge clock);
      while (resp_valid !== 1'b1) @(posedge clock);
      got_data = resp_data;
      got_len = resp_len;
      resp_ready <= 1'b0;
    end
  endtask
endmodule // sevr_ctl_model

/* File: testbench/tb_status_event_and_recall.sv */
`timescale 1ns/1ps
`include "sevr_regs.vh"
module tb_status_event_and_recall;
  reg clock, rst_n, exec_busy, local_status_message, serial_only, shutdown;
  reg trigger_mode_recall, ext_trigger, seq_empty;
  reg [7:0] std_cond, cond_a, cond_b, recall_mode_value;
  reg [15:0] seq_voltage, seq_current, seq_dwell, voltage_soft_limit, current_soft_limit;
  wire cmd_valid, cmd_ready, resp_valid, resp_ready, message_available_bit, power_on_clear_flag;
  wire setup_recall, error_shown;
  wire [3:0] cmd_code, resp_kind;
  wire [7:0] cmd_arg, resp_data, resp_len, standard_event_latch, event_latch_a, event_latch_b;
  wire [7:0] standard_event_mask, event_mask_a, event_mask_b, status_summary, setup_slot;
  wire [7:0] seq_addr, error_display;
  wire [15:0] voltage_setpoint, current_setpoint, step_dwell_time;
  integer err_total, n_compared, k;
  sevr_status_event_recall #(.B_RISE(8'hfe), .ERR_SHOW_CYCLES(8)) i_sevr_status_event_recall (.*);
  sevr_ctl_model i_sevr_ctl_model (.*);
  initial clock = 1'b0;
  always #2 clock = ~clock;
  // Sequence memory answers one cycle after the address; slot 254 is left empty.
  always @(posedge clock) begin
    seq_empty <= (seq_addr == 8'hfe);
    seq_voltage <= {8'h00, seq_addr};
    seq_current <= {8'h01, seq_addr};
    seq_dwell <= {8'h02, seq_addr};
  end
  task stop_test;
    begin
      if (err_total == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  task snd(input [3:0] c, input [7:0] a);
    i_sevr_ctl_model.send(c, a);
  endtask
  task chk_q(input [3:0] c, input [7:0] exp);
    begin
      i_sevr_ctl_model.query(c, 8'h00);
      cmp(i_sevr_ctl_model.got_data, exp);
    end
  endtask
  task pulse_down;
    begin
      @(posedge clock) shutdown <= 1'b1;
      @(posedge clock) shutdown <= 1'b0;
      tick(1);
    end
  endtask
  initial begin
    #20000;
    err_total = err_total + 1;
    stop_test;
  end
  initial begin
    {rst_n, exec_busy, local_status_message, serial_only, shutdown} = 5'h00;
    {trigger_mode_recall, ext_trigger} = 2'h0;
    {std_cond, cond_a, cond_b} = 24'h000000;
    recall_mode_value = 8'h0d;
    voltage_soft_limit = 16'h0080;
    current_soft_limit = 16'h01ff;
    err_total = 0;
    n_compared = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    tick(1);
    cmp({event_latch_a, event_latch_b}, 16'h0000);
    cmp({standard_event_latch, power_on_clear_flag}, 16'h0000);
    @(posedge clock) {cond_a, cond_b} <= 16'h0101;
    chk_q(`SEVR_CMD_READ_A, 8'h01);
    chk_q(`SEVR_CMD_READ_A, 8'h00);
    chk_q(`SEVR_CMD_READ_B, 8'h00);
    @(posedge clock) cond_b <= 8'h00;
    chk_q(`SEVR_CMD_READ_B, 8'h01);
    snd(4'hf, 8'h00);
    chk_q(`SEVR_CMD_IST, 8'h30);
    chk_q(`SEVR_CMD_READ_STD, 8'h20);
    @(posedge clock) local_status_message <= 1'b1;
    chk_q(`SEVR_CMD_IST, 8'h31);
    @(posedge clock) {serial_only, local_status_message} <= 2'b10;
    chk_q(`SEVR_CMD_IST, 8'h31);
    @(posedge clock) serial_only <= 1'b0;
    chk_q(`SEVR_CMD_IDENT, 8'h00);
    cmp(i_sevr_ctl_model.got_len, 16'd49);
    cmp(resp_kind, {12'h000, `SEVR_CMD_IDENT});
    chk_q(`SEVR_CMD_CONFIG, 8'h00);
    cmp(i_sevr_ctl_model.got_len, 16'd202);
    snd(`SEVR_CMD_MASK_A, 8'h02);
    @(posedge clock) cond_a <= 8'h03;
    tick(3);
    cmp({event_mask_a, 7'h00, status_summary[2]}, 16'h0201);
    snd(`SEVR_CMD_MASK_STD, 8'h20);
    snd(`SEVR_CMD_MASK_B, 8'h20);
    snd(4'hf, 8'h00);
    tick(1);
    cmp({standard_event_mask, 2'b00, status_summary[5:3], 3'b000}, 16'h2020);
    cmp(event_mask_b, 16'h0020);
    snd(`SEVR_CMD_CLEAR, 8'h00);
    tick(1);
    cmp({event_latch_a, standard_event_latch}, 16'h0000);
    @(posedge clock) exec_busy <= 1'b1;
    snd(`SEVR_CMD_OPC, 8'h00);
    tick(4);
    cmp(standard_event_latch[0], 16'h0000);
    @(posedge clock) exec_busy <= 1'b0;
    tick(3);
    cmp(standard_event_latch[0], 16'h0001);
    i_sevr_ctl_model.lag = 2;
    @(posedge clock) exec_busy <= 1'b1;
    fork
      chk_q(`SEVR_CMD_OPC_Q, 8'h31);
      begin
        tick(6);
        cmp(message_available_bit, 16'h0000);
        @(posedge clock) exec_busy <= 1'b0;
      end
    join
    i_sevr_ctl_model.lag = 0;
    snd(`SEVR_CMD_PSC_WR, 8'h01);
    snd(`SEVR_CMD_MASK_A, 8'h0f);
    snd(`SEVR_CMD_CLEAR, 8'h00);
    chk_q(`SEVR_CMD_PSC_Q, 8'h31);
    pulse_down;
    cmp(event_mask_a, 16'h0000);
    cmp({standard_event_mask, event_mask_b}, 16'h0000);
    snd(`SEVR_CMD_PSC_WR, 8'h00);
    snd(`SEVR_CMD_MASK_A, 8'h0f);
    pulse_down;
    cmp(event_mask_a, 16'h000f);
    snd(`SEVR_CMD_RECALL, 8'h03);
    for (k = 0; k < 8 && setup_recall !== 1'b1; k = k + 1) tick(1);
    cmp({setup_slot, 7'h00, setup_recall}, 16'h0301);
    snd(`SEVR_CMD_RECALL, 8'h0c);
    tick(4);
    cmp(voltage_setpoint, 16'h000c);
    cmp(current_setpoint ^ step_dwell_time, 16'h0300);
    snd(`SEVR_CMD_RECALL, 8'hc8);
    tick(4);
    cmp({error_display, voltage_setpoint[7:0]}, 16'h150c);
    cmp(error_shown, 16'h0001);
    chk_q(`SEVR_CMD_READ_B, 8'h20);
    tick(8);
    cmp({error_shown, error_display}, 16'h0000);
    snd(`SEVR_CMD_RECALL, 8'hfe);
    tick(4);
    cmp({error_display, voltage_setpoint[7:0]}, 16'h180c);
    chk_q(`SEVR_CMD_READ_B, 8'h20);
    snd(`SEVR_CMD_RECALL, 8'h00);
    tick(2);
    cmp({7'h00, standard_event_latch[4], voltage_setpoint[7:0]}, 16'h010c);
    @(posedge clock) trigger_mode_recall <= 1'b1;
    @(posedge clock) ext_trigger <= 1'b1;
    @(posedge clock) ext_trigger <= 1'b0;
    tick(5);
    cmp(voltage_setpoint, 16'h000d);
    stop_test;
  end
endmodule // tb_status_event_and_recall
